// ===== rtl/mpfc_pkg.sv
// Purpose: Constants for the modem pin function configuration block
// Assumes: Byte-wide registers on a plain strobe port, one clock
// Notes: Offsets are register indices; the byte address is four times each
//
// Contract
// - Separate config registers per channel, own offsets
// - Bit 7 set turns pull-up off
// - Bit 6 pull-down, never with pull-up
// - Pulls only apply while pin is input
// - Carrier pin: input, open-drain, push-pull
// - Bell pin: input, open-drain, push-pull
// - Bit 5 blocks bell wake; global gate
// - Terminal-ready pin five function codes
// - Set-ready pin four function codes
package mpfc_pkg;

   // -------------------------------------------------------------
   // Register indices
   // -------------------------------------------------------------
   localparam logic [7:0] CH0_CARRIER_IDX = 8'h2A; // Channel 0 carrier
   localparam logic [7:0] CH0_BELL_IDX = 8'h2B; // Channel 0 bell/wake
   localparam logic [7:0] CH0_TREADY_IDX = 8'h2C; // Channel 0 terminal
   localparam logic [7:0] CH0_SREADY_IDX = 8'h2D; // Channel 0 set-ready
   localparam logic [7:0] CH1_CARRIER_IDX = 8'h3D; // Channel 1 carrier
   localparam logic [7:0] CH1_BELL_IDX = 8'h3E; // Channel 1 bell/wake
   localparam logic [7:0] CH1_TREADY_IDX = 8'h3F; // Channel 1 terminal
   localparam logic [7:0] CH1_SREADY_IDX = 8'h40; // Channel 1 set-ready

   // -------------------------------------------------------------
   // Field positions and reset value
   // -------------------------------------------------------------
   localparam int WEAK_HIGH_OFF_BIT = 7; // Pull-up disable
   localparam int PULL_LOW_ON_BIT = 6; // Pull-down enable
   localparam int HOST_WAKE_BLOCK_BIT = 5; // Bell wake disable
   localparam logic [7:0] CFG_RESET = 8'h00; // All registers reset
   localparam logic [7:0] CARRIER_MASK = 8'hC3; // Writable bits
   localparam logic [7:0] BELL_MASK = 8'hE3; // Writable bits
   localparam logic [7:0] TREADY_MASK = 8'hC7; // Writable bits
   localparam logic [7:0] SREADY_MASK = 8'hC3; // Writable bits

   // -------------------------------------------------------------
   // Function codes
   // -------------------------------------------------------------
   localparam logic [2:0] FN_GP_IN = 3'h0; // GPIO input
   localparam logic [2:0] FN_GP_OD = 3'h1; // GPIO open-drain out
   localparam logic [2:0] FN_GP_PP = 3'h2; // GPIO push-pull out
   localparam logic [2:0] FN_MODEM_OD = 3'h3; // Modem open-drain
   localparam logic [2:0] FN_MODEM_PP = 3'h4; // Modem push-pull

   // Resolved driver kind of one pin
   typedef enum logic [1:0] {
      MPFC_DRV_IN,
      MPFC_DRV_OD,
      MPFC_DRV_PP
   } mpfc_drv_e;

endpackage : mpfc_pkg

// ===== rtl/mpfc_pin_drv.sv
// Purpose: Drive and pull control for one multi-function pin
// Assumes: Caller resolves the function code into a driver kind
// Notes: Combinational; the top registers the results
`timescale 1ns/10ps
module mpfc_pin_drv (
   input wire logic [1:0] kind, // Driver kind, mpfc_drv_e
   input wire logic out_val, // Level to present
   input wire logic weak_high_off, // Pull-up disable bit
   input wire logic pull_low_on, // Pull-down enable bit
   output logic pin_o, // Pin output value
   output logic pin_oe, // Pin output enable
   output logic pu_en, // Pull-up active
   output logic pd_en // Pull-down active
);

   logic is_in; // Pin is an input
   assign is_in = (kind == mpfc_pkg::MPFC_DRV_IN);

   // ---------------------------------------------------------------
   // Driver: input never drives, open-drain only pulls low
   // ---------------------------------------------------------------
   always_comb begin
      unique case (kind)
         mpfc_pkg::MPFC_DRV_OD: begin
            pin_o = 1'b0;
            pin_oe = ~out_val;
         end
         mpfc_pkg::MPFC_DRV_PP: begin
            pin_o = out_val;
            pin_oe = 1'b1;
         end
         default: begin // Input, and any stray code
            pin_o = 1'b0;
            pin_oe = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Pulls apply to inputs only; pull-up wins over pull-down
   // ---------------------------------------------------------------
   assign pu_en = is_in & ~weak_high_off;
   assign pd_en = is_in & weak_high_off & pull_low_on;

endmodule : mpfc_pin_drv

// ===== rtl/mpfc_chan.sv
// Purpose: Pin configuration of one serial channel, four modem pins
// Assumes: Registers are written by the top over a strobe port
// Notes: Instantiated once per channel, each with its own offsets
`timescale 1ns/10ps
module mpfc_chan (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [7:0] addr, // Register index
   input wire logic [7:0] wdata, // Write data
   input wire logic wr_stb, // Write strobe
   input wire logic [7:0] idx_carrier, // Carrier register index
   input wire logic [7:0] idx_bell, // Bell register index
   input wire logic [7:0] idx_tready, // Terminal register index
   input wire logic [7:0] idx_sready, // Set-ready register index
   input wire logic [3:0] gpio_out, // GPIO levels, carrier first
   input wire logic term_ready, // Modem terminal-ready level
   input wire logic [3:0] pin_i, // Sampled pin levels
   input wire logic global_wake_en, // Global remote wakeup enable
   output logic [7:0] rdata_c, // Read data when hit
   output logic hit, // Address belongs to channel
   output logic [3:0] pin_o, // Pin output values
   output logic [3:0] pin_oe, // Pin output enables
   output logic [3:0] pu_en, // Pull-up enables
   output logic [3:0] pd_en, // Pull-down enables
   output logic wake_req, // Bell pin wake request
   output logic set_ready // Modem set-ready input level
);

   logic [7:0] carrier_q; // Carrier pin config
   logic [7:0] bell_q; // Bell pin config
   logic [7:0] tready_q; // Terminal-ready pin config
   logic [7:0] sready_q; // Set-ready pin config
   logic [1:0] kind [4]; // Driver kind per pin
   logic [3:0] val; // Level per pin
   logic [3:0] wk_hi_off; // Pull-up disable per pin
   logic [3:0] pl_lo_on; // Pull-down enable per pin

   // ---------------------------------------------------------------
   // Register writes; reserved bits kept at zero
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         carrier_q <= mpfc_pkg::CFG_RESET;
         bell_q <= mpfc_pkg::CFG_RESET;
         tready_q <= mpfc_pkg::CFG_RESET;
         sready_q <= mpfc_pkg::CFG_RESET;
      end else if (wr_stb) begin
         if (addr == idx_carrier) begin
            carrier_q <= wdata & mpfc_pkg::CARRIER_MASK;
         end
         if (addr == idx_bell) begin
            bell_q <= wdata & mpfc_pkg::BELL_MASK;
         end
         if (addr == idx_tready) begin
            tready_q <= wdata & mpfc_pkg::TREADY_MASK;
         end
         if (addr == idx_sready) begin
            sready_q <= wdata & mpfc_pkg::SREADY_MASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      hit = 1'b1;
      if (addr == idx_carrier) begin
         rdata_c = carrier_q;
      end else if (addr == idx_bell) begin
         rdata_c = bell_q;
      end else if (addr == idx_tready) begin
         rdata_c = tready_q;
      end else if (addr == idx_sready) begin
         rdata_c = sready_q;
      end else begin
         rdata_c = 8'h00;
         hit = 1'b0;
      end
   end

   // Two-bit GPIO codes; 11 falls back to input (illegal except on set-ready)
   function automatic logic [1:0] gp_kind(input logic [1:0] c);
      unique case (c)
         2'h1: gp_kind = mpfc_pkg::MPFC_DRV_OD;
         2'h2: gp_kind = mpfc_pkg::MPFC_DRV_PP;
         default: gp_kind = mpfc_pkg::MPFC_DRV_IN;
      endcase
   endfunction : gp_kind

   // ---------------------------------------------------------------
   // Function decode per pin
   // ---------------------------------------------------------------
   always_comb begin
      kind[0] = gp_kind(carrier_q[1:0]);
      kind[1] = gp_kind(bell_q[1:0]);
      kind[3] = gp_kind(sready_q[1:0]); // (11 is modem input)
      val = gpio_out;
      unique case (tready_q[2:0])
         mpfc_pkg::FN_GP_OD: kind[2] = mpfc_pkg::MPFC_DRV_OD;
         mpfc_pkg::FN_GP_PP: kind[2] = mpfc_pkg::MPFC_DRV_PP;
         mpfc_pkg::FN_MODEM_OD: begin
            kind[2] = mpfc_pkg::MPFC_DRV_OD;
            val[2] = ~term_ready; // Active-low modem line
         end
         mpfc_pkg::FN_MODEM_PP: begin
            kind[2] = mpfc_pkg::MPFC_DRV_PP;
            val[2] = ~term_ready;
         end
         default: kind[2] = mpfc_pkg::MPFC_DRV_IN; // Input, illegal codes
      endcase
      wk_hi_off = {sready_q[7], tready_q[7], bell_q[7], carrier_q[7]};
      pl_lo_on = {sready_q[6], tready_q[6], bell_q[6], carrier_q[6]};
   end

   // ---------------------------------------------------------------
   // One driver slice per pin
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_pin
      mpfc_pin_drv u_drv (
         .kind(kind[g]),
         .out_val(val[g]),
         .weak_high_off(wk_hi_off[g]),
         .pull_low_on(pl_lo_on[g]),
         .pin_o(pin_o[g]),
         .pin_oe(pin_oe[g]),
         .pu_en(pu_en[g]),
         .pd_en(pd_en[g])
      );
   end

   // Bell wake: low level on an input-configured pin, gated twice
   assign wake_req = global_wake_en & ~bell_q[mpfc_pkg::HOST_WAKE_BLOCK_BIT]
                     & (kind[1] == mpfc_pkg::MPFC_DRV_IN) & ~pin_i[1];
   // Modem set-ready input, active low, only in its modem function
   assign set_ready = (sready_q[1:0] == 2'h3) & ~pin_i[3];

endmodule : mpfc_chan

// ===== rtl/mpfc_top.sv
// Purpose: Modem pin function configuration for two channels
// Assumes: Plain strobe register port, read data one cycle later
// Notes: Pin vectors are ordered carrier, bell, terminal, set-ready
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module mpfc_top (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [7:0] reg_addr, // Register index
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic global_wake_en, // Global remote wakeup enable
   input wire logic [3:0] ch0_gpio_out, // Channel 0 GPIO levels
   input wire logic [3:0] ch1_gpio_out, // Channel 1 GPIO levels
   input wire logic ch0_term_ready, // Channel 0 modem terminal-ready
   input wire logic ch1_term_ready, // Channel 1 modem terminal-ready
   input wire logic [3:0] ch0_pin_i, // Channel 0 pin levels
   input wire logic [3:0] ch1_pin_i, // Channel 1 pin levels
   output logic [3:0] ch0_pin_o, // Channel 0 pin outputs
   output logic [3:0] ch0_pin_oe, // Channel 0 output enables
   output logic [3:0] ch0_pu_en, // Channel 0 pull-ups
   output logic [3:0] ch0_pd_en, // Channel 0 pull-downs
   output logic [3:0] ch1_pin_o, // Channel 1 pin outputs
   output logic [3:0] ch1_pin_oe, // Channel 1 output enables
   output logic [3:0] ch1_pu_en, // Channel 1 pull-ups
   output logic [3:0] ch1_pd_en, // Channel 1 pull-downs
   output logic ch0_wake_req, // Channel 0 bell wake request
   output logic ch1_wake_req, // Channel 1 bell wake request
   output logic ch0_set_ready, // Channel 0 set-ready level
   output logic ch1_set_ready // Channel 1 set-ready level
);

   logic [7:0] rd0, rd1; // Channel read data
   logic hit0, hit1; // Channel address hits
   logic [3:0] o0, oe0, pu0, pd0, o1, oe1, pu1, pd1; // Raw pin controls
   logic w0, w1, s0, s1; // Raw wake and set-ready

   // ---------------------------------------------------------------
   // Channels at their own offsets
   // ---------------------------------------------------------------
   mpfc_chan u_ch0 (
      .clk(clk), .sys_rst(sys_rst), .addr(reg_addr), .wdata(reg_wdata),
      .wr_stb(reg_wr), .idx_carrier(mpfc_pkg::CH0_CARRIER_IDX),
      .idx_bell(mpfc_pkg::CH0_BELL_IDX),
      .idx_tready(mpfc_pkg::CH0_TREADY_IDX),
      .idx_sready(mpfc_pkg::CH0_SREADY_IDX), .gpio_out(ch0_gpio_out),
      .term_ready(ch0_term_ready), .pin_i(ch0_pin_i),
      .global_wake_en(global_wake_en), .rdata_c(rd0), .hit(hit0),
      .pin_o(o0), .pin_oe(oe0), .pu_en(pu0), .pd_en(pd0),
      .wake_req(w0), .set_ready(s0)
   );
   mpfc_chan u_ch1 (
      .clk(clk), .sys_rst(sys_rst), .addr(reg_addr), .wdata(reg_wdata),
      .wr_stb(reg_wr), .idx_carrier(mpfc_pkg::CH1_CARRIER_IDX),
      .idx_bell(mpfc_pkg::CH1_BELL_IDX),
      .idx_tready(mpfc_pkg::CH1_TREADY_IDX),
      .idx_sready(mpfc_pkg::CH1_SREADY_IDX), .gpio_out(ch1_gpio_out),
      .term_ready(ch1_term_ready), .pin_i(ch1_pin_i),
      .global_wake_en(global_wake_en), .rdata_c(rd1), .hit(hit1),
      .pin_o(o1), .pin_oe(oe1), .pu_en(pu1), .pd_en(pd1),
      .wake_req(w1), .set_ready(s1)
   );

   // ---------------------------------------------------------------
   // Read data: registered, zero for unmapped or idle
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && hit0) begin
         reg_rdata <= rd0;
      end else if (reg_rd && hit1) begin
         reg_rdata <= rd1;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Output registers; reset leaves every pin an undriven input
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {ch0_pin_o, ch0_pin_oe, ch0_pu_en, ch0_pd_en} <= 16'h00F0;
         {ch1_pin_o, ch1_pin_oe, ch1_pu_en, ch1_pd_en} <= 16'h00F0;
         {ch0_wake_req, ch1_wake_req} <= 2'h0;
         {ch0_set_ready, ch1_set_ready} <= 2'h0;
      end else begin
         {ch0_pin_o, ch0_pin_oe, ch0_pu_en, ch0_pd_en} <= {o0, oe0, pu0, pd0};
         {ch1_pin_o, ch1_pin_oe, ch1_pu_en, ch1_pd_en} <= {o1, oe1, pu1, pd1};
         {ch0_wake_req, ch1_wake_req} <= {w0, w1};
         {ch0_set_ready, ch1_set_ready} <= {s0, s1};
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_pull_excl: assert property ((ch0_pu_en & ch0_pd_en) == 4'h0)
      else $error("pull-up and pull-down both on");
   a_pull_input: assert property (
      ((ch0_pu_en | ch0_pd_en) & ch0_pin_oe) == 4'h0)
      else $error("pull active on a driving pin");
   a_od_low: assert property (((ch0_pin_oe & ch0_pin_o) != 4'h0) |->
      $past(u_ch0.kind[0] == mpfc_pkg::MPFC_DRV_PP
      || u_ch0.kind[1] == mpfc_pkg::MPFC_DRV_PP
      || u_ch0.kind[2] == mpfc_pkg::MPFC_DRV_PP
      || u_ch0.kind[3] == mpfc_pkg::MPFC_DRV_PP))
      else $error("high driven without push-pull");
   a_pu_off: assert property ((reg_wr && reg_wdata == 8'h80
      && reg_addr == mpfc_pkg::CH0_CARRIER_IDX) |-> ##2 !ch0_pu_en[0])
      else $error("pull-up still on");
   a_pu_on: assert property ((reg_wr && reg_wdata == 8'h00
      && reg_addr == mpfc_pkg::CH1_CARRIER_IDX) |-> ##2 ch1_pu_en[0])
      else $error("pull-up not on");
   a_carrier_pp: assert property ((reg_wr && reg_wdata[1:0] == 2'h2
      && reg_addr == mpfc_pkg::CH0_CARRIER_IDX) |-> ##2 ch0_pin_oe[0])
      else $error("carrier push-pull not driving");
   a_bell_in: assert property ((reg_wr && reg_wdata[1:0] == 2'h0
      && reg_addr == mpfc_pkg::CH0_BELL_IDX) |-> ##2 !ch0_pin_oe[1])
      else $error("bell input driving");
   a_wake_block: assert property (u_ch0.bell_q[5] |=> !ch0_wake_req)
      else $error("wake despite block bit");
   a_tready_modem: assert property ((u_ch0.tready_q[2:0] == 3'h4) |=>
      ch0_pin_oe[2] && ch0_pin_o[2] == $past(~ch0_term_ready))
      else $error("terminal-ready modem output wrong");
   a_sready_in: assert property ((u_ch0.sready_q[1:0] == 2'h3) |=>
      !ch0_pin_oe[3] && ch0_set_ready == $past(~ch0_pin_i[3]))
      else $error("set-ready modem input wrong");
   a_chan_sep: assert property ((reg_wr
      && reg_addr == mpfc_pkg::CH0_TREADY_IDX) |=> $stable(u_ch1.tready_q))
      else $error("channel 1 changed by channel 0 write");

   c_wake: cover property (ch0_wake_req);
   c_modem_pair: cover property (u_ch0.tready_q[2:0] == 3'h3
      && u_ch0.sready_q[1:0] == 2'h3);
   c_od_low: cover property (ch1_pin_oe[0] && !ch1_pin_o[0]);

endmodule : mpfc_top

// ===== sim/mpfc_line_model.sv
// Purpose: Far-side model of the four modem-control lines of one channel
// Assumes: One model per channel, four lines each
// Notes: A line nobody drives or pulls wanders, so stale levels show up
`timescale 1ns/10ps
module mpfc_line_model (
   input wire logic clk, // System clock
   input wire logic [3:0] pin_o, // Block output values
   input wire logic [3:0] pin_oe, // Block output enables
   input wire logic [3:0] pu_en, // Block pull-ups
   input wire logic [3:0] pd_en, // Block pull-downs
   input wire logic [3:0] ext_en, // Far side drives the line
   input wire logic [3:0] ext_val, // Far side level
   output logic [3:0] pin_i // Resolved line level
);
   // -------------------------------------------------------------
   // Line resolution
   // -------------------------------------------------------------
   logic [3:0] flt_q; // Inverse of last level, for floating lines

   // Floating lines toggle so a missing pull is never hidden
   always_ff @(posedge clk) begin
      flt_q <= ~pin_i;
   end

   // Block driver wins, then far side, then the weak pulls
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         if (pin_oe[b]) begin
            pin_i[b] = pin_o[b];
         end else if (ext_en[b]) begin
            pin_i[b] = ext_val[b];
         end else if (pu_en[b]) begin
            pin_i[b] = 1'b1;
         end else if (pd_en[b]) begin
            pin_i[b] = 1'b0;
         end else begin
            pin_i[b] = flt_q[b];
         end
      end
   end
endmodule : mpfc_line_model

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the modem pin configuration block
// Assumes: Strobe register port, outputs one stage after config
// Notes: Only legal function codes and zero reserved bits are written
`timescale 1ns/10ps
module tb_top;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic clk, sys_rst, reg_wr, reg_rd, global_wake_en; // Bench drives
   logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register port
   logic [3:0] ch0_gpio_out, ch1_gpio_out, ch0_pin_i, ch1_pin_i; // Levels
   logic ch0_term_ready, ch1_term_ready, ch0_wake_req, ch1_wake_req;
   logic ch0_set_ready, ch1_set_ready; // Modem input levels
   logic [3:0] ch0_pin_o, ch0_pin_oe, ch0_pu_en, ch0_pd_en; // Channel 0
   logic [3:0] ch1_pin_o, ch1_pin_oe, ch1_pu_en, ch1_pd_en; // Channel 1
   logic [3:0] ext0_en, ext1_en, ext0_val, ext1_val; // Far side drive
   int num_errors, compares; // Report counters

   mpfc_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .global_wake_en(global_wake_en),
      .ch0_gpio_out(ch0_gpio_out), .ch1_gpio_out(ch1_gpio_out),
      .ch0_term_ready(ch0_term_ready), .ch1_term_ready(ch1_term_ready),
      .ch0_pin_i(ch0_pin_i), .ch1_pin_i(ch1_pin_i),
      .ch0_pin_o(ch0_pin_o), .ch0_pin_oe(ch0_pin_oe),
      .ch0_pu_en(ch0_pu_en), .ch0_pd_en(ch0_pd_en),
      .ch1_pin_o(ch1_pin_o), .ch1_pin_oe(ch1_pin_oe),
      .ch1_pu_en(ch1_pu_en), .ch1_pd_en(ch1_pd_en),
      .ch0_wake_req(ch0_wake_req), .ch1_wake_req(ch1_wake_req),
      .ch0_set_ready(ch0_set_ready), .ch1_set_ready(ch1_set_ready));
   mpfc_line_model line0_u (.clk(clk), .pin_o(ch0_pin_o),
      .pin_oe(ch0_pin_oe), .pu_en(ch0_pu_en), .pd_en(ch0_pd_en),
      .ext_en(ext0_en), .ext_val(ext0_val), .pin_i(ch0_pin_i));
   mpfc_line_model line1_u (.clk(clk), .pin_o(ch1_pin_o),
      .pin_oe(ch1_pin_oe), .pu_en(ch1_pu_en), .pd_en(ch1_pd_en),
      .ext_en(ext1_en), .ext_val(ext1_val), .pin_i(ch1_pin_i));

   // -------------------------------------------------------------
   // Clock, closing report and watchdog
   // -------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // Cuts a hang short; no wait below should come near this
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end

   // -------------------------------------------------------------
   // Access and check tasks, all entered right after a clock edge
   // -------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // One idle edge, so a following write never reassigns the strobe
      @(posedge clk);
   endtask : reg_write

   // Read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
      @(posedge clk);
   endtask : reg_read

   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
   endtask : do_reset

   // Expected {oe, o, pull-up, pull-down} of pin p for config cfg
   function automatic logic [3:0] exp_pins(input int p,
         input logic [7:0] cfg, input logic gv);
      logic [2:0] c;
      logic od, pp, inp;
      c = (p == 2) ? cfg[2:0] : {1'b0, cfg[1:0]};
      od = (c == 3'h1) || (p == 2 && c == 3'h3);
      pp = (c == 3'h2) || (p == 2 && c == 3'h4);
      inp = !od && !pp;
      return {pp | (od & ~gv), pp & gv, inp & ~cfg[7], inp & cfg[7] & cfg[6]};
   endfunction : exp_pins

   // Program one pin, then compare its driver and pulls
   task automatic pin_case(input int ch, input int p, input logic [7:0] cfg,
                           input logic gv);
      logic [3:0] e, oe, o, pu, pd;
      e = exp_pins(p, cfg, gv);
      ch0_gpio_out <= {4{gv}};
      ch1_gpio_out <= {4{gv}};
      ch0_term_ready <= ~gv;
      ch1_term_ready <= ~gv;
      reg_write(((ch == 0) ? 8'h2A : 8'h3D) + 8'(p), cfg);
      @(posedge clk);
      #1;
      oe = (ch == 0) ? ch0_pin_oe : ch1_pin_oe;
      o = (ch == 0) ? ch0_pin_o : ch1_pin_o;
      pu = (ch == 0) ? ch0_pu_en : ch1_pu_en;
      pd = (ch == 0) ? ch0_pd_en : ch1_pd_en;
      chk("pin_oe", {7'h00, e[3]}, {7'h00, oe[p]});
      if (e[3]) chk("pin_o", {7'h00, e[2]}, {7'h00, o[p]});
      chk("pu_en", {7'h00, e[1]}, {7'h00, pu[p]});
      chk("pd_en", {7'h00, e[0]}, {7'h00, pd[p]});
      @(posedge clk);
   endtask : pin_case

   // Far side holds input pin p at extv; compare wake or set-ready
   task automatic line_case(input int ch, input int p, input logic [7:0] cfg,
                            input logic g, input logic extv, input logic e);
      logic s;
      ext0_en <= (ch == 0) ? (4'h1 << p) : 4'h0;
      ext1_en <= (ch == 1) ? (4'h1 << p) : 4'h0;
      ext0_val <= {4{extv}};
      ext1_val <= {4{extv}};
      global_wake_en <= g;
      reg_write(((ch == 0) ? 8'h2A : 8'h3D) + 8'(p), cfg);
      repeat (2) @(posedge clk);
      #1;
      if (p == 1) s = (ch == 0) ? ch0_wake_req : ch1_wake_req;
      else s = (ch == 0) ? ch0_set_ready : ch1_set_ready;
      chk((p == 1) ? "wake_req" : "set_ready", {7'h00, e}, {7'h00, s});
      // Far side keeps driving; the next case sets both enables afresh
      @(posedge clk);
   endtask : line_case

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   logic [7:0] idx_tab [8] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D,
                               8'h3D, 8'h3E, 8'h3F, 8'h40}; // Both channels
   logic [7:0] val_tab [8] = '{8'h81, 8'h61, 8'h44, 8'hC2,
                               8'h42, 8'hA2, 8'h83, 8'h01}; // Zero reserved

   initial begin
      num_errors = 0;
      compares = 0;
      // Reset high from time zero, so no edge sees unreset outputs
      {sys_rst, reg_wr, reg_rd, global_wake_en} = 4'h8;
      {reg_addr, reg_wdata} = 16'h0000;
      {ch0_gpio_out, ch1_gpio_out, ext0_en, ext1_en} = 16'h0000;
      {ext0_val, ext1_val} = 8'h00;
      {ch0_term_ready, ch1_term_ready} = 2'h0;
      do_reset();
      // Reset values and per-channel copies
      for (int i = 0; i < 8; i++) reg_read(idx_tab[i], 8'h00);
      for (int i = 0; i < 8; i++) reg_write(idx_tab[i], val_tab[i]);
      for (int i = 0; i < 8; i++) reg_read(idx_tab[i], val_tab[i]);
      reg_write(8'h2E, 8'h01);
      reg_read(8'h2E, 8'h00);
      // Pull combinations on an input, then on every function code
      for (int b = 0; b < 4; b++) pin_case(0, 0, {b[1:0], 6'h00}, 1'b0);
      for (int c = 0; c < 3; c++) begin
         for (int g = 0; g < 2; g++) begin
            pin_case(0, 0, {2'b11, 4'h0, c[1:0]}, g[0]);
            pin_case(1, 0, {2'b00, 4'h0, c[1:0]}, g[0]);
            pin_case(0, 1, {2'b10, 4'h0, c[1:0]}, g[0]);
            pin_case(1, 1, {2'b11, 4'h0, c[1:0]}, g[0]);
         end
      end
      for (int c = 0; c < 5; c++) begin
         if (c == 3) reg_write(8'h2D, 8'h03);
         for (int g = 0; g < 2; g++) begin
            pin_case(0, 2, {2'b11, 3'h0, c[2:0]}, g[0]);
         end
      end
      for (int c = 0; c < 4; c++) begin
         if (c == 3) reg_write(8'h3F, 8'h04);
         for (int g = 0; g < 2; g++) begin
            pin_case(1, 3, {2'b11, 4'h0, c[1:0]}, g[0]);
         end
      end
      // Bell wake gating and the set-ready modem input
      line_case(0, 1, 8'h00, 1'b1, 1'b0, 1'b1);
      line_case(0, 1, 8'h20, 1'b1, 1'b0, 1'b0);
      line_case(0, 1, 8'h00, 1'b0, 1'b0, 1'b0);
      line_case(0, 1, 8'h00, 1'b1, 1'b1, 1'b0);
      line_case(1, 1, 8'h00, 1'b1, 1'b0, 1'b1);
      line_case(1, 3, 8'h03, 1'b0, 1'b0, 1'b1);
      line_case(1, 3, 8'h03, 1'b0, 1'b1, 1'b0);
      line_case(0, 3, 8'h00, 1'b0, 1'b0, 1'b0);
      // Second reset in mid-run returns every setting to default
      do_reset();
      reg_read(8'h3E, 8'h00);
      #1;
      chk("ch1_pu_en", 8'h0F, {4'h0, ch1_pu_en});
      chk("ch0_pin_oe", 8'h00, {4'h0, ch0_pin_oe});
      report_and_stop();
   end
endmodule : tb_top
